//--- rtc_sram.sv
/*
 * Byte-wide SRAM with BCD clock registers at the top eight locations.
 * Assumes a synchronous view of the SRAM bus, supply-level comparator
 * inputs and a one-cycle pulse per 32,768 Hz oscillator period.
 */
`timescale 1ns/1ns
`include "rtc_sram_consts.svh"

module rtc_sram #(
    parameter int unsigned REC_CYCLES = `POWER_UP_RECOVERY_TIME_CYCLES
) (
    input  wire logic                   clk_i,          // 125 MHz clock
    input  wire logic                   reset_n_i,      // async reset, active low
    input  wire rtc_sram_pkg::sram_bus_s bus_i,         // host bus
    input  wire logic                   above_pfd_i,    // supply above deselect threshold
    input  wire logic                   above_vso_i,    // supply above battery threshold
    input  wire logic                   osc_tick_i,     // 32,768 Hz tick pulse
    output logic [7:0]                  data_o,         // read data
    output logic [7:0]                  data_oe_o,      // data drive enable
    output logic                        on_battery_o    // battery supplies the part
);
    localparam int unsigned RW = 28;

    // ==========================================================
    // reset release
    logic rst_meta_reg, rst_n_reg;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ==========================================================
    // power states
    rtc_sram_pkg::pwr_state_e pwr_reg;
    logic [RW-1:0]            rec_cnt_reg;
    logic                     bus_ok;
    assign bus_ok = (pwr_reg == rtc_sram_pkg::PWR_ON);

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pwr_reg     <= rtc_sram_pkg::PWR_OFF;
            rec_cnt_reg <= '0;
        end else begin
            unique case (pwr_reg)
                rtc_sram_pkg::PWR_OFF: begin
                    if (above_pfd_i) begin
                        pwr_reg     <= rtc_sram_pkg::PWR_RECOVER;
                        rec_cnt_reg <= '0;
                    end else if (!above_vso_i) begin
                        pwr_reg <= rtc_sram_pkg::PWR_BATTERY;     // R2
                    end
                end
                rtc_sram_pkg::PWR_BATTERY: begin
                    if (above_vso_i) begin
                        pwr_reg <= rtc_sram_pkg::PWR_OFF;         // R2
                    end
                end
                rtc_sram_pkg::PWR_RECOVER: begin
                    if (!above_pfd_i) begin
                        pwr_reg <= rtc_sram_pkg::PWR_OFF;
                    end else if (rec_cnt_reg == RW'(REC_CYCLES - 1)) begin
                        pwr_reg <= rtc_sram_pkg::PWR_ON;          // R3 R4
                    end
                    rec_cnt_reg <= rec_cnt_reg + 1'b1;
                end
                rtc_sram_pkg::PWR_ON: begin
                    if (!above_pfd_i) begin
                        pwr_reg <= rtc_sram_pkg::PWR_OFF;         // R1
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            on_battery_o <= 1'b0;
        end else begin
            on_battery_o <= (pwr_reg == rtc_sram_pkg::PWR_BATTERY);
        end
    end

    // ==========================================================
    // bus decode; inputs ignored unless powered and recovered
    logic sel, wr, rd, clk_area;
    assign sel      = bus_ok && !bus_i.ce_n;                        // R1
    assign wr       = sel && !bus_i.we_n;
    assign rd       = sel && bus_i.we_n && !bus_i.oe_n;
    assign clk_area = (bus_i.addr >= `OFS_CTRL);

    // ==========================================================
    // memory below the clock registers
    logic [7:0] mem [0:32767];
    always_ff @(posedge clk_i) begin
        if (wr && !clk_area) begin
            mem[bus_i.addr] <= bus_i.wdata;                        // R24
        end
    end

    // ==========================================================
    // functions
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                            input logic [7:0] hi, output logic wrap);
        wrap = (v >= hi);
        if (wrap) begin
            bcd_inc = lo;
        end else if (v[3:0] >= 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};                      // R13
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8));
        unique case (m)
            8'h02:                      month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default:                    month_end = 8'h31;
        endcase
    endfunction : month_end

    // ==========================================================
    // control register, register copies and counters
    logic [7:0]          ctrl_reg;
    rtc_sram_pkg::time_s regs_reg;   // host-visible copies
    rtc_sram_pkg::time_s cnt_reg;    // running counters
    logic                set_hold_q;
    logic                sec_pulse;
    logic                hold;
    assign hold = ctrl_reg[`BIT_SET_HOLD] || ctrl_reg[`BIT_READ_HOLD];

    // next second of the counters, all fields in one step
    rtc_sram_pkg::time_s cnt_next;
    always_comb begin
        logic w0, w1, w2, w3, w4, w5, wd;
        logic [7:0] dend;
        cnt_next = cnt_reg;
        w0 = 1'b0; w1 = 1'b0; w2 = 1'b0; w3 = 1'b0; w4 = 1'b0; w5 = 1'b0; wd = 1'b0;
        dend = month_end(cnt_reg.month, cnt_reg.year);
        cnt_next.sec[6:0] = bcd_inc({1'b0, cnt_reg.sec[6:0]}, 8'h00, 8'h59, w0)
                            [6:0];                                 // R13
        if (w0) begin
            cnt_next.min = bcd_inc(cnt_reg.min, 8'h00, 8'h59, w1);
        end
        if (w0 && w1) begin
            cnt_next.hour = bcd_inc(cnt_reg.hour, 8'h00, 8'h23, w2); // R14
        end
        if (w0 && w1 && w2) begin
            cnt_next.cent_day[2:0] = bcd_inc({5'h00, cnt_reg.cent_day[2:0]},
                                             8'h01, 8'h07, wd)[2:0];
            cnt_next.date = bcd_inc(cnt_reg.date, 8'h01, dend, w3);
        end
        if (w0 && w1 && w2 && w3) begin
            cnt_next.month = bcd_inc(cnt_reg.month, 8'h01, 8'h12, w4);
        end
        if (w0 && w1 && w2 && w3 && w4) begin
            cnt_next.year = bcd_inc(cnt_reg.year, 8'h00, 8'h99, w5);
            if (w5 && cnt_reg.cent_day[`BIT_CENT_EN]) begin
                cnt_next.cent_day[`BIT_CENT_FLAG] =
                    !cnt_reg.cent_day[`BIT_CENT_FLAG];             // R16
            end
        end
    end

    // host writes to the control register
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg   <= 8'h00;
            set_hold_q <= 1'b0;
        end else begin
            if (wr && bus_i.addr == `OFS_CTRL) begin
                ctrl_reg <= bus_i.wdata;                           // R5 R9 R18
            end
            set_hold_q <= ctrl_reg[`BIT_SET_HOLD];
        end
    end

    // counters: loaded on set-hold release, else advance each second
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cnt_reg <= '{year: 8'h00, month: `RESET_DATE, date: `RESET_DATE,
                         cent_day: `RESET_DATE, hour: 8'h00, min: 8'h00, sec: 8'h00};
        end else if (set_hold_q && !ctrl_reg[`BIT_SET_HOLD]) begin
            cnt_reg <= regs_reg;                                   // R10
        end else begin
            if (sec_pulse) begin
                cnt_reg <= cnt_next;                               // R6
            end
            if (wr && bus_i.addr == `OFS_CENT_DAY) begin
                cnt_reg.cent_day[5:4] <= bus_i.wdata[5:4];         // R17
            end
            if (wr && bus_i.addr == `OFS_SEC) begin
                cnt_reg.sec[`BIT_OSC_HALT] <= bus_i.wdata[`BIT_OSC_HALT]; // R15
            end
            if (!bus_ok) begin
                cnt_reg.cent_day[`BIT_FREQ_TEST] <= 1'b0;          // R23
            end
        end
    end

    // host-visible copies: refreshed as a whole every cycle when not held
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            regs_reg <= '0;
        end else begin
            if (!hold) begin
                regs_reg <= cnt_reg;                               // R7 R8 R11
            end
            if (!bus_ok) begin
                regs_reg.cent_day[`BIT_FREQ_TEST] <= 1'b0;         // R23
            end else if (wr && clk_area && bus_i.addr != `OFS_CTRL) begin
                unique case (bus_i.addr)
                    `OFS_SEC:      regs_reg.sec      <= bus_i.wdata;
                    `OFS_MIN:      regs_reg.min      <= bus_i.wdata;
                    `OFS_HOUR:     regs_reg.hour     <= bus_i.wdata;
                    `OFS_CENT_DAY: regs_reg.cent_day <= bus_i.wdata;
                    `OFS_DATE:     regs_reg.date     <= bus_i.wdata;
                    `OFS_MONTH:    regs_reg.month    <= bus_i.wdata;
                    default:       regs_reg.year     <= bus_i.wdata;
                endcase
            end
        end
    end

    // ==========================================================
    // divider chain with calibration at the divide-by-256 stage
    // one bit wider than a nominal second so a lengthened second fits
    logic [15:0] div_reg;
    logic [15:0] sec_len;
    logic [5:0]  sec_in_min_reg;
    logic [5:0]  min_in_cycle_reg;
    logic        adj_done_reg;
    logic        adjust;
    assign adjust = !adj_done_reg && (min_in_cycle_reg < {ctrl_reg[4:0], 1'b0}); // R19
    always_comb begin
        sec_len = 16'(`OSC_PER_SEC);
        if (adjust) begin
            sec_len = ctrl_reg[`BIT_CAL_SIGN] ? 16'(`OSC_PER_SEC) - 16'(`OSC_SHORTEN)
                                              : 16'(`OSC_PER_SEC) + 16'(`OSC_LENGTHEN); // R20
        end
    end
    logic osc_run;
    assign osc_run   = osc_tick_i && !cnt_reg.sec[`BIT_OSC_HALT];  // R15
    assign sec_pulse = osc_run && (div_reg >= sec_len);

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            div_reg          <= '0;
            sec_in_min_reg   <= '0;
            min_in_cycle_reg <= '0;
            adj_done_reg     <= 1'b0;
        end else if (osc_run) begin
            if (sec_pulse) begin
                div_reg <= '0;
                if (adjust) begin
                    adj_done_reg <= 1'b1;                          // R19
                end
                if (sec_in_min_reg == `SEC_PER_MIN) begin
                    sec_in_min_reg   <= '0;
                    adj_done_reg     <= 1'b0;
                    min_in_cycle_reg <= (min_in_cycle_reg == `CAL_CYCLE_MIN) ? 6'd0
                                        : min_in_cycle_reg + 6'd1;
                end else begin
                    sec_in_min_reg <= sec_in_min_reg + 6'd1;
                end
            end else begin
                div_reg <= div_reg + 16'h0001;
            end
        end
    end

    // uncalibrated 512 Hz test tone from a free 6-bit prescaler
    logic [5:0] tone_div_reg;
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tone_div_reg <= '0;
        end else if (osc_run) begin
            tone_div_reg <= tone_div_reg + 6'd1;                   // R22
        end
    end

    // ==========================================================
    // read data and output drive
    logic [7:0] clk_rd;
    always_comb begin
        unique case (bus_i.addr[2:0])
            3'h0:    clk_rd = ctrl_reg;
            3'h1:    clk_rd = regs_reg.sec;
            3'h2:    clk_rd = regs_reg.min;
            3'h3:    clk_rd = regs_reg.hour;
            3'h4:    clk_rd = regs_reg.cent_day;
            3'h5:    clk_rd = regs_reg.date;
            3'h6:    clk_rd = regs_reg.month;
            default: clk_rd = regs_reg.year;
        endcase
        if (bus_i.addr == `OFS_SEC && regs_reg.cent_day[`BIT_FREQ_TEST]
            && !cnt_reg.sec[`BIT_OSC_HALT]) begin
            clk_rd[0] = tone_div_reg[5];                           // R21
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            data_o    <= 8'h00;
            data_oe_o <= 8'h00;
        end else begin
            data_o    <= clk_area ? clk_rd : mem[bus_i.addr];
            data_oe_o <= rd ? 8'hFF : 8'h00;                       // R1
        end
    end

endmodule : rtc_sram

//--- rtc_sram_consts.svh
/*
 * Constants of the battery-backed BCD clock SRAM: register offsets,
 * field positions and timing counts.
 * Assumes a 125 MHz system clock and a 32,768 Hz oscillator tick input.
 */
// Summary of operation
// R1 - in deselect window: deselect, block writes, tri-state data, ignore bus
// R2 - below switchover threshold run on battery; keep memory and clock alive
// R3 - after power return, writes stay blocked for a recovery interval
// R4 - recovery interval lasts between 40 and 200 milliseconds
// R5 - read-hold bit D6 of 7FF8h stops register copy updates while one
// R6 - held copies show time current at hold request; counters keep running
// R7 - all copies update together; hold never cuts an update short
// R8 - after read-hold clears, copies refresh within one second
// R9 - set-hold bit D7 of 7FF8h also freezes copy updates
// R10 - clearing set-hold loads 7FF9h-7FFFh into counters, then counting resumes
// R11 - first update after set-hold clears occurs within one second
// R12 - software writes freq-test bit and fixed-zero bits as zero
// R13 - time and date are packed BCD with documented ranges
// R14 - hour counts 00-23 in 24-hour packed BCD
// R15 - seconds MSB halts oscillator; clearing restarts within one second
// R16 - century flag inverts at century rollover when enabled
// R17 - century enable and flag writable without set-hold
// R18 - calibration magnitude D4-D0, D5 sign: one speeds up
// R19 - 64 minute cycle; first 2N minutes adjust one second by 128 or 256
// R20 - calibration blanks or splits pulses at the divide-by-256 stage
// R21 - freq-test with oscillator running toggles data line zero at 512Hz on seconds read
// R22 - test output taken ahead of calibration
// R23 - freq-test bit cleared on every power-up
// R24 - array below clock registers is plain read/write memory
`ifndef RTC_SRAM_CONSTS_SVH
`define RTC_SRAM_CONSTS_SVH

`define ADDR_W            15
`define OFS_CTRL          15'h7FF8
`define OFS_SEC           15'h7FF9
`define OFS_MIN           15'h7FFA
`define OFS_HOUR          15'h7FFB
`define OFS_CENT_DAY      15'h7FFC
`define OFS_DATE          15'h7FFD
`define OFS_MONTH         15'h7FFE
`define OFS_YEAR          15'h7FFF
`define BIT_SET_HOLD      7
`define BIT_READ_HOLD     6
`define BIT_CAL_SIGN      5
`define BIT_OSC_HALT      7
`define BIT_FREQ_TEST     6
`define BIT_CENT_EN       5
`define BIT_CENT_FLAG     4
`define CENT_BITS_MASK    8'h30
`define SEC_PER_MIN       6'd59
`define CAL_CYCLE_MIN     6'd63
`define OSC_PER_SEC       15'h7FFF
`define OSC_SHORTEN       15'h0080
`define OSC_LENGTHEN      15'h0100
`define POWER_UP_RECOVERY_TIME_MIN_MS       40
`define POWER_UP_RECOVERY_TIME_MAX_MS       200
`define CLK_MHZ           125
`define POWER_UP_RECOVERY_TIME_CYCLES       ((`POWER_UP_RECOVERY_TIME_MIN_MS + `POWER_UP_RECOVERY_TIME_MAX_MS) / 2 * 1000 * `CLK_MHZ)
`define RESET_DATE        8'h01

`endif

//--- rtc_sram_pkg.sv
/*
 * Types of the battery-backed BCD clock SRAM.
 * Assumes rtc_sram_consts.svh is not needed here; types only.
 */
package rtc_sram_pkg;

    typedef enum logic [1:0] {
        PWR_OFF     = 2'b00,
        PWR_BATTERY = 2'b01,
        PWR_RECOVER = 2'b10,
        PWR_ON      = 2'b11
    } pwr_state_e;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] cent_day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } time_s;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [14:0] addr;
        logic [7:0]  wdata;
    } sram_bus_s;

endpackage : rtc_sram_pkg

//--- rtc_sram_props.sv
/* Port checker for rtc_sram: supply gating, read answers, battery flag.
   Assumes it is bound into every rtc_sram instance. */
`timescale 1ns/1ns
// ============================================================
// checker
module rtc_sram_props #(
    parameter int unsigned REC_CYCLES = 50
) (
    input wire logic                    clk_i,        // clock
    input wire logic                    reset_n_i,    // reset, active low
    input wire rtc_sram_pkg::sram_bus_s bus_i,        // host bus
    input wire logic                    above_pfd_i,  // supply valid
    input wire logic                    above_vso_i,  // above battery level
    input wire logic                    osc_tick_i,   // oscillator tick
    input wire logic [7:0]              data_o,       // read data
    input wire logic [7:0]              data_oe_o,    // data drive
    input wire logic                    on_battery_o  // battery state
);
    logic [31:0] pfd_cnt_reg;  // cycles of valid supply
    logic [2:0]  age_reg;      // cycles since reset, saturating
    logic        rd_req;
    assign rd_req = !bus_i.ce_n && bus_i.we_n && !bus_i.oe_n;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pfd_cnt_reg <= 32'h0;
        end else begin
            pfd_cnt_reg <= above_pfd_i ? pfd_cnt_reg + 32'h1 : 32'h0;
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            age_reg <= 3'h0;
        end else if (age_reg != 3'h7) begin
            age_reg <= age_reg + 3'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    deselect_quiet_a: assert property (!above_pfd_i [*2] |=> data_oe_o == 8'h00)
        else $error("data driven while supply invalid");
    idle_quiet_a: assert property ((bus_i.ce_n || !bus_i.we_n || bus_i.oe_n)
        |=> data_oe_o == 8'h00) else $error("data driven without read");
    recovery_gate_a: assert property (data_oe_o != 8'h00 |-> pfd_cnt_reg >= REC_CYCLES)
        else $error("bus served before recovery ended");
    recovery_hold_a: assert property ($rose(above_pfd_i) |=> (data_oe_o == 8'h00) [*8])
        else $error("bus served right after supply return");
    read_answer_a: assert property (rd_req && above_pfd_i && pfd_cnt_reg > REC_CYCLES + 4
        |=> data_oe_o == 8'hFF) else $error("read not answered");
    battery_on_a: assert property ((age_reg == 3'h7 && !above_vso_i) [*3] |-> on_battery_o)
        else $error("battery state missing");
    battery_off_a: assert property ((age_reg == 3'h7 && above_vso_i) [*3] |-> !on_battery_o)
        else $error("battery state stuck");
    battery_quiet_a: assert property (on_battery_o |-> data_oe_o == 8'h00)
        else $error("data driven on battery");
    cover property (rd_req ##2 data_oe_o == 8'hFF);
    cover property (on_battery_o ##1 !on_battery_o);
    cover property ($rose(above_pfd_i));
endmodule : rtc_sram_props

bind rtc_sram rtc_sram_props #(.REC_CYCLES(REC_CYCLES)) i_props (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i), .above_pfd_i(above_pfd_i),
    .above_vso_i(above_vso_i), .osc_tick_i(osc_tick_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .on_battery_o(on_battery_o)
);

//--- rtc_host.sv
/* Host processor model on the byte-wide bus.
   Assumes the device answers a read one edge after taking it. */
`timescale 1ns/1ns
// ============================================================
// host model
module rtc_host (
    input  wire logic [7:0]         clk_i,      // clock
    input  wire logic [7:0]         data_i,     // read data
    input  wire logic [7:0]         data_oe_i,  // read data drive
    output rtc_sram_pkg::sram_bus_s bus_o       // bus to the device
);
    initial bus_o = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0, wdata: 8'h00};
    // released strobes go high; address and data lines show inverted old values, never a stale copy
    task automatic release_bus();
        bus_o.ce_n = 1'b1;
        bus_o.oe_n = 1'b1;
        bus_o.we_n = 1'b1;
        bus_o.addr = ~bus_o.addr;
        bus_o.wdata = ~bus_o.wdata;
    endtask : release_bus
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        @(posedge clk_i[0]);
        #1 bus_o = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: a, wdata: d};
        @(posedge clk_i[0]);
        #1 release_bus();
    endtask : wr
    task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i[0]);
        #1 bus_o = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: a, wdata: ~bus_o.wdata};
        repeat (2) @(posedge clk_i[0]);
        #1 d = data_i;
        ok = (data_oe_i === 8'hFF);
        release_bus();
    endtask : rd
endmodule : rtc_host

//--- rtc_sram_tb.sv
/* Testbench for rtc_sram: host model on the bus, supply levels and ticks
   from the bench. Assumes the recovery count shortened to 50 cycles. */
`timescale 1ns/1ns
`include "rtc_sram_consts.svh"
// ============================================================
// bench
module rtc_sram_tb;
    localparam int unsigned REC = 50;
    logic                    clk_i       = 1'b0;
    logic                    reset_n_i   = 1'b0;
    logic                    above_pfd_i = 1'b0;
    logic                    above_vso_i = 1'b0;
    logic                    osc_tick_i  = 1'b0;
    logic [7:0]              data_o;
    logic [7:0]              data_oe_o;
    logic                    on_battery_o;
    rtc_sram_pkg::sram_bus_s bus;
    logic [7:0]              rv;
    logic                    rok;
    int                      n_fail      = 0;
    int                      cmp_count   = 0;

    always #4 clk_i = ~clk_i;
    // one tick every second clock: 65,536 clocks make a second
    always @(posedge clk_i) #1 osc_tick_i = ~osc_tick_i;

    rtc_sram #(.REC_CYCLES(REC)) i_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .above_pfd_i(above_pfd_i),
        .above_vso_i(above_vso_i), .osc_tick_i(osc_tick_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .on_battery_o(on_battery_o)
    );
    rtc_host i_host (.clk_i({7'h0, clk_i}), .data_i(data_o), .data_oe_i(data_oe_o), .bus_o(bus));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp, input string what);
        i_host.rd(a, rv, rok);
        check({what, " drive"}, 8'h01, {7'h0, rok});
        check(what, exp, rv);
    endtask : rd_chk
    task automatic test_supply();
        cyc(4);
        check("battery", 8'h01, {7'h0, on_battery_o});
        i_host.rd(`OFS_CTRL, rv, rok);
        check("dead read", 8'h00, {7'h0, rok});
        above_vso_i = 1'b1;
        cyc(4);
        check("mains", 8'h00, {7'h0, on_battery_o});
        above_pfd_i = 1'b1;
        i_host.rd(`OFS_CTRL, rv, rok);
        check("early read", 8'h00, {7'h0, rok});
        cyc(REC);
        rd_chk(`OFS_CTRL, 8'h00, "ctrl");
        i_host.wr(15'h0000, 8'hA5);
        i_host.wr(15'h7FF7, 8'h5A);
        rd_chk(15'h0000, 8'hA5, "ram low");
        rd_chk(15'h7FF7, 8'h5A, "ram top");
    endtask : test_supply
    task automatic test_set_clock();
        i_host.wr(`OFS_CTRL, 8'h80);
        i_host.wr(`OFS_SEC, 8'h59);
        i_host.wr(`OFS_MIN, 8'h59);
        i_host.wr(`OFS_HOUR, 8'h23);
        i_host.wr(`OFS_CENT_DAY, 8'h37);
        i_host.wr(`OFS_DATE, 8'h31);
        i_host.wr(`OFS_MONTH, 8'h12);
        i_host.wr(`OFS_YEAR, 8'h99);
        i_host.wr(`OFS_CTRL, 8'h00);
        i_host.wr(`OFS_CTRL, 8'h40);
        rd_chk(`OFS_HOUR, 8'h23, "loaded hour");
        cyc(66000);
        rd_chk(`OFS_SEC, 8'h59, "held sec");
        i_host.wr(`OFS_CTRL, 8'h00);
        cyc(4);
        rd_chk(`OFS_MIN, 8'h00, "min");
        rd_chk(`OFS_HOUR, 8'h00, "hour");
        rd_chk(`OFS_CENT_DAY, 8'h21, "cent day");
        rd_chk(`OFS_DATE, 8'h01, "date");
        rd_chk(`OFS_MONTH, 8'h01, "month");
        rd_chk(`OFS_YEAR, 8'h00, "year");
        i_host.rd(`OFS_SEC, rv, rok);
        check("sec", 8'h00, rv);
        i_host.wr(`OFS_CENT_DAY, 8'h11);
        rd_chk(`OFS_CENT_DAY, 8'h11, "cent direct");
    endtask : test_set_clock
    // two seconds reads 32 ticks apart
    task automatic tone(input logic flip, input string what);
        logic b;
        i_host.rd(`OFS_SEC, rv, rok);
        b = rv[0];
        cyc(61);
        i_host.rd(`OFS_SEC, rv, rok);
        check(what, {7'h0, b ^ flip}, {7'h0, rv[0]});
    endtask : tone
    task automatic test_tone();
        i_host.wr(`OFS_CTRL, 8'h80);
        i_host.wr(`OFS_CENT_DAY, 8'h41);
        i_host.wr(`OFS_CTRL, 8'h25);
        tone(1'b1, "tone");
        i_host.wr(`OFS_CTRL, 8'h80);
        i_host.wr(`OFS_SEC, 8'h80);
        i_host.wr(`OFS_CTRL, 8'h00);
        tone(1'b0, "halted tone");
        i_host.wr(`OFS_SEC, 8'h00);
        tone(1'b1, "restarted tone");
    endtask : test_tone
    task automatic test_power_cycle();
        above_pfd_i = 1'b0;
        cyc(2);
        i_host.wr(15'h0000, 8'hFF);
        i_host.rd(15'h0000, rv, rok);
        check("deselect read", 8'h00, {7'h0, rok});
        above_vso_i = 1'b0;
        cyc(4);
        check("battery again", 8'h01, {7'h0, on_battery_o});
        above_vso_i = 1'b1;
        cyc(2);
        above_pfd_i = 1'b1;
        cyc(REC + 4);
        rd_chk(`OFS_CENT_DAY, 8'h01, "test bit cleared");
        rd_chk(15'h0000, 8'hA5, "kept ram");
    endtask : test_power_cycle
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    initial begin
        cyc(6);
        reset_n_i = 1'b1;
        test_supply();
        test_set_clock();
        test_tone();
        test_power_cycle();
        wrap_up();
    end
    initial begin
        cyc(80000);
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule : rtc_sram_tb
